//--- hdl/flash_pkg.sv
// package: constants, types and register map of the flash write/erase control
package flash_pkg;
	localparam int ADDR_W = 14;
	localparam int FLASH_BYTES = 16384;
	localparam int PAGE_W = 9;
	localparam int PAIR_W = PAGE_W - 1;
	localparam logic [7:0] KEY_FIRST = 8'hA5;
	localparam logic [7:0] KEY_SECOND = 8'hF1;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;
	localparam logic [7:0] REG_RESET = 8'h00;
	// register offsets
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] KEY_OFS = 8'h01;
	localparam logic [7:0] PREFETCH_OFS = 8'h02;
	localparam logic [7:0] TIMING_OFS = 8'h03;
	localparam logic [7:0] MONITOR_OFS = 8'h04;
	localparam logic [7:0] CAUSE_OFS = 8'h05;
	localparam logic [7:0] STATUS_OFS = 8'h06;
	// field positions
	localparam int WEN_BIT = 0;
	localparam int EEN_BIT = 1;
	localparam int BWS_BIT = 0;
	localparam int TIMING_W = 4;
	localparam int MON_EN_BIT = 0;
	localparam int MON_RST_BIT = 1;
	localparam int MON_LVL_BIT = 2;
	localparam int FERR_BIT = 6;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_KEY_BIT = 1;
	localparam int ST_BLOCK_BIT = 3;
	localparam int ST_INIT_BIT = 4;
	localparam int ST_EVEN_BIT = 5;
	// timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int PROG_TIME_NS = 20000;
	localparam int ERASE_TIME_NS = 40000;
	localparam int TIMER_W = 12;
	localparam logic [TIMER_W-1:0] PROG_CYCLES =
		TIMER_W'((PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [TIMER_W-1:0] ERASE_CYCLES =
		TIMER_W'((ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [TIMER_W-1:0] TIMER_ONE = 12'h001;

	typedef enum logic [1:0] {KEY_LOCKED, KEY_HALF, KEY_OPEN, KEY_BLOCKED}
		key_state_type;
	typedef enum logic [1:0] {OP_IDLE, OP_PROG, OP_ERASE} op_state_type;

	typedef struct packed {
		logic wr;
		logic [15:0] addr;
		logic [7:0] data;
	} mem_write_type;

	typedef struct packed {
		logic en;
		logic erase;
		logic [ADDR_W-1:0] addr;
		logic [15:0] data;
	} flash_write_type;
endpackage : flash_pkg

//--- hdl/key_tracker.sv
// module: lock and key sequence tracker for flash modification
module key_tracker (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic soft_clear,
	input wire logic key_wr,
	input wire logic [7:0] key_data,
	input wire logic op_attempt,
	input wire logic op_done,
	output flash_pkg::key_state_type key_state
);
	import flash_pkg::*;

	key_state_type key_state_reg;
	key_state_type key_state_next;

	assign key_state = key_state_reg;

	// next key state
	always_comb begin
		key_state_next = key_state_reg;
		case (key_state_reg)
			KEY_LOCKED: begin
				if (key_wr) begin
					key_state_next = (key_data == KEY_FIRST) ? KEY_HALF : KEY_BLOCKED;
				end else if (op_attempt) begin
					key_state_next = KEY_BLOCKED;
				end
			end
			KEY_HALF: begin
				if (key_wr) begin
					key_state_next = (key_data == KEY_SECOND) ? KEY_OPEN : KEY_BLOCKED;
				end else if (op_attempt) begin
					key_state_next = KEY_BLOCKED;
				end
			end
			KEY_OPEN: begin
				if (key_wr) begin
					key_state_next = KEY_BLOCKED; // out of order
				end else if (op_done) begin
					key_state_next = KEY_LOCKED;
				end
			end
			KEY_BLOCKED: key_state_next = KEY_BLOCKED;
			default: key_state_next = KEY_BLOCKED;
		endcase
		if (soft_clear) begin
			key_state_next = KEY_LOCKED;
		end
	end

	// state register
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			key_state_reg <= KEY_LOCKED;
		end else begin
			key_state_reg <= key_state_next;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	a_wrong_key_blocks: assert property (
		key_wr && !soft_clear && key_state_reg == KEY_LOCKED &&
		key_data != KEY_FIRST |=> key_state_reg == KEY_BLOCKED)
		else $error("wrong first key did not block");
	a_block_sticks: assert property (
		key_state_reg == KEY_BLOCKED && !soft_clear |=>
		key_state_reg == KEY_BLOCKED)
		else $error("blocked key state left without reset");
	a_early_attempt: assert property (
		op_attempt && !key_wr && !soft_clear &&
		key_state_reg inside {KEY_LOCKED, KEY_HALF} |=>
		key_state_reg == KEY_BLOCKED)
		else $error("attempt before key did not block");
	a_done_relocks: assert property (
		op_done && !key_wr && !soft_clear && key_state_reg == KEY_OPEN |=>
		key_state_reg == KEY_LOCKED)
		else $error("key not relocked after operation");
	c_key_open: cover property (key_state_reg == KEY_OPEN);
endmodule : key_tracker

//--- hdl/flash_array.sv
// module: flash byte array with and-program, erase write and code read
module flash_array (
	input wire logic clk_sys,
	input wire logic resetn,
	input flash_pkg::flash_write_type flash_wr,
	input wire logic [flash_pkg::ADDR_W-1:0] rd_addr,
	output logic [7:0] rd_data
);
	import flash_pkg::*;

	logic [7:0] mem [FLASH_BYTES];
	logic [7:0] rd_data_reg;
	logic [7:0] rd_data_next;
	logic [ADDR_W-1:0] lo_addr;
	logic [ADDR_W-1:0] hi_addr;
	logic [7:0] exp_lo_reg;

	assign rd_data = rd_data_reg;
	assign lo_addr = {flash_wr.addr[ADDR_W-1:1], 1'b0};
	assign hi_addr = {flash_wr.addr[ADDR_W-1:1], 1'b1};

	// read path
	always_comb begin
		rd_data_next = mem[rd_addr];
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rd_data_reg <= REG_RESET;
		end else begin
			rd_data_reg <= rd_data_next;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (flash_wr.en) begin
			mem[lo_addr] <= flash_wr.erase ? ERASED_BYTE :
				(mem[lo_addr] & flash_wr.data[7:0]);
			mem[hi_addr] <= flash_wr.erase ? ERASED_BYTE :
				(mem[hi_addr] & flash_wr.data[15:8]);
		end
	end

	// expected low byte, for checking only
	always_ff @(posedge clk_sys) begin
		exp_lo_reg <= flash_wr.erase ? ERASED_BYTE :
			(mem[lo_addr] & flash_wr.data[7:0]);
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	a_program_ands: assert property (
		flash_wr.en && !flash_wr.erase |=>
		mem[$past(lo_addr)] == exp_lo_reg)
		else $error("program did not and the byte");
	a_erase_ones: assert property (
		flash_wr.en && flash_wr.erase |=>
		mem[$past(hi_addr)] == ERASED_BYTE)
		else $error("erased byte not all ones");
endmodule : flash_array

//--- hdl/flash_write_erase_keyed_control.sv
// module: keyed flash write and page erase sequencer, top level
module flash_write_erase_keyed_control (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input flash_pkg::mem_write_type mov_req,
	output flash_pkg::mem_write_type xram_wr,
	output logic core_stall,
	input wire logic [flash_pkg::ADDR_W-1:0] code_addr,
	output logic [7:0] code_data,
	input wire logic store_initialised,
	output logic flash_error_reset
);
	import flash_pkg::*;
	// software registers
	logic wen_reg, wen_next;
	logic een_reg, een_next;
	logic bws_reg, bws_next;
	logic [TIMING_W-1:0] timing_reg, timing_next;
	logic mon_en_reg, mon_en_next;
	logic mon_rst_reg, mon_rst_next;
	logic mon_lvl_reg, mon_lvl_next;
	logic ferr_reg, ferr_next;
	logic init_s1_reg, init_s2_reg;
	logic [7:0] reg_rdata_reg, reg_rdata_next;
	// operation state
	op_state_type op_state_reg, op_state_next;
	logic [TIMER_W-1:0] timer_reg, timer_next;
	logic [PAGE_W-1:0] walk_reg, walk_next;
	logic [ADDR_W-1:0] op_addr_reg, op_addr_next;
	logic [15:0] op_data_reg, op_data_next;
	logic even_valid_reg, even_valid_next;
	logic [ADDR_W-2:0] even_addr_reg, even_addr_next;
	logic [7:0] even_data_reg, even_data_next;
	logic core_stall_reg, core_stall_next;
	logic err_reg, err_next;
	mem_write_type xram_reg, xram_next;
	// decode
	key_state_type key_state;
	flash_write_type flash_wr;
	logic soft_clear, key_wr, attempt, eligible, mon_ok, err;
	logic key_attempt, go, erase_go, prog_go, even_latch, op_done, ev_ok;
	assign reg_rdata = reg_rdata_reg;
	assign xram_wr = xram_reg;
	assign core_stall = core_stall_reg;
	assign flash_error_reset = err_reg;
	// pair data: unused byte is all ones, so anding leaves it alone
	function automatic logic [15:0] pair_data(input logic bws,
		input logic odd, input logic ev_ok_i, input logic [7:0] d,
		input logic [7:0] ev);
		if (!bws) begin
			pair_data = odd ? {d, ERASED_BYTE} : {ERASED_BYTE, d};
		end else begin
			pair_data = {d, ev_ok_i ? ev : ERASED_BYTE};
		end
	endfunction : pair_data
	// request decode; the error pulse acts as the internal system reset
	assign soft_clear = err_reg;
	assign key_wr = reg_wr && reg_addr == KEY_OFS && !soft_clear;
	assign attempt = mov_req.wr && wen_reg && op_state_reg == OP_IDLE &&
		!soft_clear;
	assign eligible = attempt && init_s2_reg && key_state != KEY_BLOCKED;
	assign mon_ok = mon_en_reg && mon_rst_reg;
	assign err = eligible && !mon_ok;
	assign key_attempt = eligible && mon_ok;
	assign go = key_attempt && key_state == KEY_OPEN;
	assign erase_go = go && een_reg;
	assign prog_go = go && !een_reg && (!bws_reg || mov_req.addr[0]);
	assign even_latch = go && !een_reg && bws_reg && !mov_req.addr[0];
	assign ev_ok = even_valid_reg &&
		even_addr_reg == mov_req.addr[ADDR_W-1:1];
	assign op_done = even_latch ||
		(op_state_reg != OP_IDLE && timer_reg == TIMER_ONE);
	key_tracker u_key (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.soft_clear(soft_clear),
		.key_wr(key_wr),
		.key_data(reg_wdata),
		.op_attempt(key_attempt),
		.op_done(op_done),
		.key_state(key_state)
	);
	// flash array write port: erase walks the page two bytes a cycle
	always_comb begin
		flash_wr.en = (op_state_reg == OP_PROG && timer_reg == TIMER_ONE) ||
			(op_state_reg == OP_ERASE && !walk_reg[PAIR_W]);
		flash_wr.erase = op_state_reg == OP_ERASE;
		flash_wr.data = op_data_reg;
		flash_wr.addr = flash_wr.erase ? {op_addr_reg[ADDR_W-1:PAGE_W],
			walk_reg[PAIR_W-1:0], 1'b0} : op_addr_reg;
	end
	flash_array u_array (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.flash_wr(flash_wr),
		.rd_addr(code_addr),
		.rd_data(code_data)
	);
	// software register writes and read mux
	always_comb begin
		wen_next = wen_reg;
		een_next = een_reg;
		bws_next = bws_reg;
		timing_next = timing_reg;
		mon_en_next = mon_en_reg;
		mon_rst_next = mon_rst_reg;
		mon_lvl_next = mon_lvl_reg;
		ferr_next = ferr_reg;
		if (reg_wr) begin
			case (reg_addr)
				CTRL_OFS: begin
					wen_next = reg_wdata[WEN_BIT];
					een_next = reg_wdata[EEN_BIT];
				end
				PREFETCH_OFS: bws_next = reg_wdata[BWS_BIT];
				TIMING_OFS: timing_next = reg_wdata[TIMING_W-1:0];
				MONITOR_OFS: begin
					mon_en_next = reg_wdata[MON_EN_BIT];
					mon_rst_next = reg_wdata[MON_RST_BIT];
					mon_lvl_next = reg_wdata[MON_LVL_BIT];
				end
				default: ;
			endcase
		end
		if (soft_clear) begin
			wen_next = 1'b0;
			een_next = 1'b0;
			bws_next = 1'b0;
			timing_next = '0;
			mon_en_next = 1'b0;
			mon_rst_next = 1'b0;
			mon_lvl_next = 1'b0;
			ferr_next = 1'b1;
		end
		reg_rdata_next = REG_RESET;
		if (reg_rd) begin
			case (reg_addr)
				CTRL_OFS: begin
					reg_rdata_next[WEN_BIT] = wen_reg;
					reg_rdata_next[EEN_BIT] = een_reg;
				end
				PREFETCH_OFS: reg_rdata_next[BWS_BIT] = bws_reg;
				TIMING_OFS: reg_rdata_next[TIMING_W-1:0] = timing_reg;
				MONITOR_OFS: begin
					reg_rdata_next[MON_EN_BIT] = mon_en_reg;
					reg_rdata_next[MON_RST_BIT] = mon_rst_reg;
					reg_rdata_next[MON_LVL_BIT] = mon_lvl_reg;
				end
				CAUSE_OFS: reg_rdata_next[FERR_BIT] = ferr_reg;
				STATUS_OFS: begin
					reg_rdata_next[ST_BUSY_BIT] = core_stall_reg;
					reg_rdata_next[ST_KEY_BIT+:2] = 2'(key_state);
					reg_rdata_next[ST_BLOCK_BIT] = key_state == KEY_BLOCKED;
					reg_rdata_next[ST_INIT_BIT] = init_s2_reg;
					reg_rdata_next[ST_EVEN_BIT] = even_valid_reg;
				end
				default: reg_rdata_next = REG_RESET;
			endcase
		end
	end
	// operation sequencer
	always_comb begin
		op_state_next = op_state_reg;
		timer_next = timer_reg;
		walk_next = walk_reg;
		op_addr_next = op_addr_reg;
		op_data_next = op_data_reg;
		even_valid_next = even_valid_reg;
		even_addr_next = even_addr_reg;
		even_data_next = even_data_reg;
		if (!walk_reg[PAIR_W]) begin
			walk_next = PAGE_W'(walk_reg + 1'b1);
		end
		case (op_state_reg)
			OP_IDLE: begin
				if (erase_go) begin
					op_state_next = OP_ERASE;
					timer_next = ERASE_CYCLES;
					walk_next = '0;
					op_addr_next = {mov_req.addr[ADDR_W-1:PAGE_W], PAGE_W'(0)};
				end else if (prog_go) begin
					op_state_next = OP_PROG;
					timer_next = PROG_CYCLES;
					op_addr_next = {mov_req.addr[ADDR_W-1:1], 1'b0};
					op_data_next = pair_data(bws_reg, mov_req.addr[0], ev_ok,
						mov_req.data, even_data_reg);
					even_valid_next = 1'b0;
				end else if (even_latch) begin
					even_valid_next = 1'b1;
					even_addr_next = mov_req.addr[ADDR_W-1:1];
					even_data_next = mov_req.data;
				end
			end
			OP_PROG, OP_ERASE: begin
				timer_next = TIMER_W'(timer_reg - TIMER_ONE);
				if (timer_reg == TIMER_ONE) begin
					op_state_next = OP_IDLE;
				end
			end
			default: op_state_next = OP_IDLE;
		endcase
		if (soft_clear) begin
			op_state_next = OP_IDLE;
			timer_next = '0;
			even_valid_next = 1'b0;
		end
	end
	assign core_stall_next = op_state_next != OP_IDLE;
	assign err_next = err;
	always_comb begin
		xram_next = mov_req;
		xram_next.wr = mov_req.wr && !wen_reg;
	end
	// checking helpers: length of each stall and its kind
	logic [TIMER_W-1:0] stall_len_reg, stall_len_next;
	logic was_prog_reg, was_prog_next;
	assign stall_len_next = core_stall_reg ?
		TIMER_W'(stall_len_reg + TIMER_ONE) : '0;
	assign was_prog_next = prog_go || (was_prog_reg && !erase_go);
	// register all state
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			wen_reg <= 1'b0;
			een_reg <= 1'b0;
			bws_reg <= 1'b0;
			timing_reg <= '0;
			mon_en_reg <= 1'b0;
			mon_rst_reg <= 1'b0;
			mon_lvl_reg <= 1'b0;
			ferr_reg <= 1'b0;
			init_s1_reg <= 1'b0;
			init_s2_reg <= 1'b0;
			reg_rdata_reg <= REG_RESET;
			op_state_reg <= OP_IDLE;
			timer_reg <= '0;
			walk_reg <= {1'b1, PAIR_W'(0)};
			op_addr_reg <= '0;
			op_data_reg <= '0;
			even_valid_reg <= 1'b0;
			even_addr_reg <= '0;
			even_data_reg <= REG_RESET;
			core_stall_reg <= 1'b0;
			err_reg <= 1'b0;
			xram_reg <= '0;
			stall_len_reg <= '0;
			was_prog_reg <= 1'b0;
		end else begin
			wen_reg <= wen_next;
			een_reg <= een_next;
			bws_reg <= bws_next;
			timing_reg <= timing_next;
			mon_en_reg <= mon_en_next;
			mon_rst_reg <= mon_rst_next;
			mon_lvl_reg <= mon_lvl_next;
			ferr_reg <= ferr_next;
			init_s1_reg <= store_initialised;
			init_s2_reg <= init_s1_reg;
			reg_rdata_reg <= reg_rdata_next;
			op_state_reg <= op_state_next;
			timer_reg <= timer_next;
			walk_reg <= walk_next;
			op_addr_reg <= op_addr_next;
			op_data_reg <= op_data_next;
			even_valid_reg <= even_valid_next;
			even_addr_reg <= even_addr_next;
			even_data_reg <= even_data_next;
			core_stall_reg <= core_stall_next;
			err_reg <= err_next;
			xram_reg <= xram_next;
			stall_len_reg <= stall_len_next;
			was_prog_reg <= was_prog_next;
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	a_prog_time_same: assert property (
		$fell(core_stall_reg) && was_prog_reg && !soft_clear |->
		stall_len_reg == PROG_CYCLES)
		else $error("program stall length wrong");
	a_stall_on_op: assert property (
		prog_go |=> core_stall_reg [*8])
		else $error("core not stalled during program");
	a_error_reset: assert property (
		err |=> flash_error_reset ##1 ferr_reg && !wen_reg)
		else $error("no error reset on monitor off");
	a_monitor_gate: assert property (
		$rose(flash_error_reset) |-> !$past(mon_ok))
		else $error("error reset with monitor enabled");
	a_route_flash: assert property (
		mov_req.wr && wen_reg |=> !xram_wr.wr)
		else $error("redirected write reached data memory");
	a_route_plain: assert property (
		mov_req.wr && !wen_reg && !key_wr && !soft_clear |=>
		xram_wr.wr && $stable(key_state) && !core_stall_reg)
		else $error("plain write disturbed flash path");
	a_erase_walk: assert property (
		erase_go |=> ##256 walk_reg == {1'b1, PAIR_W'(0)} &&
		op_state_reg == OP_ERASE)
		else $error("page erase walk length wrong");
	a_erase_start: assert property (
		erase_go |=> op_state_reg == OP_ERASE)
		else $error("erase not started");
	a_single_prog: assert property (
		go && !een_reg && !bws_reg |=> op_state_reg == OP_PROG)
		else $error("single byte write did not program");
	a_even_waits: assert property (
		even_latch |=> !core_stall_reg && even_valid_reg)
		else $error("even byte did not wait for odd");
	a_uninit_ignored: assert property (
		attempt && !init_s2_reg |=> op_state_reg == OP_IDLE &&
		!flash_error_reset)
		else $error("uninitialised flash was modified");
	c_erase: cover property (erase_go);
	c_pair: cover property (prog_go && bws_reg && ev_ok);
	c_error: cover property (flash_error_reset);
	c_blocked: cover property (key_state == KEY_BLOCKED);
endmodule : flash_write_erase_keyed_control

//--- sim/core_model.sv
// core model: register bus master and external write issuer
module core_model (
	input wire logic clk_sys,
	input wire logic core_stall,
	input wire logic [7:0] reg_rdata,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	output flash_pkg::mem_write_type mov_req
);
	timeunit 1ns;
	timeprecision 1ps;
	import flash_pkg::*;

	// idle bus at time zero
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		mov_req = '0;
	end

	// one-cycle write strobe
	task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : reg_write

	// read strobe; data stands only in the next cycle
	task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask : reg_read

	task automatic unlock();
		reg_write(KEY_OFS, KEY_FIRST);
		reg_write(KEY_OFS, KEY_SECOND);
	endtask : unlock

	// external write; a stalled core issues nothing
	task automatic external_move_instruction(input logic [15:0] a, input logic [7:0] d);
		while (core_stall !== 1'b0) @(posedge clk_sys);
		@(posedge clk_sys);
		mov_req <= {1'b1, a, d};
		@(posedge clk_sys);
		mov_req.wr <= 1'b0;
	endtask : external_move_instruction
endmodule : core_model

//--- sim/tb_top.sv
// testbench: keyed flash write and erase control
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import flash_pkg::*;

	logic clk_sys;
	logic resetn = 1'b0;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [7:0] reg_rdata;
	mem_write_type mov_req;
	mem_write_type xram_wr;
	logic core_stall;
	logic [ADDR_W-1:0] code_addr = '0;
	logic [7:0] code_data;
	logic store_initialised = 1'b1;
	logic flash_error_reset;
	int miscompares = 0;
	int n_compared = 0;
	int cycles = 0;
	int n;

	core_model u_core (.clk_sys(clk_sys), .core_stall(core_stall),
		.reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .mov_req(mov_req));

	flash_write_erase_keyed_control u_dut (.clk_sys(clk_sys),
		.resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.mov_req(mov_req), .xram_wr(xram_wr), .core_stall(core_stall),
		.code_addr(code_addr), .code_data(code_data),
		.store_initialised(store_initialised),
		.flash_error_reset(flash_error_reset));

	// 100 MHz clock
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	// cut a hang short
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 40000) begin
			miscompares++;
			end_of_test();
		end
	end

	// value compare
	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// register compare
	task automatic chk_reg(input string what, input logic [7:0] a,
		input logic [7:0] exp);
		logic [7:0] d;
		u_core.reg_read(a, d);
		chk(what, exp, d);
	endtask : chk_reg

	// code read compare, data one cycle after the address
	task automatic chk_code(input logic [13:0] a, input logic [7:0] exp);
		@(posedge clk_sys);
		code_addr <= a;
		@(posedge clk_sys);
		#1;
		chk("code byte", exp, code_data);
	endtask : chk_code

	// count stall cycles after a write
	task automatic op_len(output int k);
		k = 0;
		#1;
		while (core_stall === 1'b1 && k < 5000) begin
			@(posedge clk_sys);
			#1;
			k++;
		end
	endtask : op_len

	// reset, then let the init pin through its synchroniser
	task automatic do_reset();
		resetn <= 1'b0;
		repeat (8) @(posedge clk_sys);
		resetn <= 1'b1;
		repeat (3) @(posedge clk_sys);
	endtask : do_reset

	// monitor high level with reset source
	task automatic setup();
		u_core.reg_write(MONITOR_OFS, 8'h07);
		u_core.reg_write(TIMING_OFS, 8'h00);
	endtask : setup

	task automatic prog(input logic [15:0] a, input logic [7:0] d,
		output int k);
		u_core.unlock();
		u_core.reg_write(CTRL_OFS, 8'h01);
		u_core.external_move_instruction(a, d);
		op_len(k);
		u_core.reg_write(CTRL_OFS, 8'h00);
	endtask : prog

	// ordinary data write with enable clear
	task automatic t_plain();
		chk_reg("status", STATUS_OFS, 8'h10);
		u_core.reg_write(8'h7F, 8'hAA);
		chk_reg("unmapped", 8'h7F, 8'h00);
		u_core.reg_write(KEY_OFS, KEY_FIRST);
		u_core.external_move_instruction(16'h8123, 8'h3C);
		#1;
		chk("xram", {1'b1, 16'h8123, 8'h3C}, xram_wr);
		chk_reg("status", STATUS_OFS, 8'h12);
		$display("test plain done");
	endtask : t_plain

	// modify attempt with monitor or its reset source off
	task automatic t_error();
		logic [7:0] mon[3];
		mon = '{8'h00, 8'h01, 8'h02};
		foreach (mon[i]) begin
			u_core.reg_write(MONITOR_OFS, mon[i]);
			u_core.reg_write(CTRL_OFS, 8'h01);
			u_core.external_move_instruction(16'h0200, 8'h00);
			#1;
			chk("error pulse", 1, flash_error_reset);
			@(posedge clk_sys);
			#1;
			chk("pulse end", 0, flash_error_reset);
			chk_reg("cause", CAUSE_OFS, 8'h40);
			chk_reg("ctrl", CTRL_OFS, 8'h00);
		end
		do_reset();
		chk_reg("cause", CAUSE_OFS, 8'h00);
		$display("test error done");
	endtask : t_error

	// page erase
	task automatic t_erase();
		setup();
		u_core.unlock();
		u_core.reg_write(CTRL_OFS, 8'h02);
		u_core.reg_write(CTRL_OFS, 8'h03);
		u_core.external_move_instruction(16'h0234, 8'h00);
		op_len(n);
		chk("erase length", ERASE_CYCLES, n);
		u_core.reg_write(CTRL_OFS, 8'h00);
		chk_code(14'h0200, ERASED_BYTE);
		chk_code(14'h03FF, ERASED_BYTE);
		chk_reg("status", STATUS_OFS, 8'h10);
		$display("test erase done");
	endtask : t_erase

	// single byte program and bit clearing
	task automatic t_single();
		u_core.reg_write(PREFETCH_OFS, 8'h00);
		prog(16'h0210, 8'h5A, n);
		chk("prog length", PROG_CYCLES, n);
		chk_code(14'h0210, 8'h5A);
		chk_code(14'h0211, ERASED_BYTE);
		chk_reg("status", STATUS_OFS, 8'h10);
		prog(16'h0210, 8'hF0, n);
		chk_code(14'h0210, 8'h50);
		$display("test single done");
	endtask : t_single

	// two-byte block program
	task automatic t_block();
		u_core.reg_write(PREFETCH_OFS, 8'h01);
		prog(16'h0220, 8'h12, n);
		chk("even stall", 0, n);
		chk_reg("status", STATUS_OFS, 8'h30);
		chk_code(14'h0220, ERASED_BYTE);
		prog(16'h0221, 8'h34, n);
		chk("block length", PROG_CYCLES, n);
		chk_code(14'h0220, 8'h12);
		chk_code(14'h0221, 8'h34);
		prog(16'h0222, 8'hFF, n);
		prog(16'h0223, 8'h77, n);
		chk_code(14'h0222, ERASED_BYTE);
		chk_code(14'h0223, 8'h77);
		$display("test block done");
	endtask : t_block

	// wrong first code blocks until reset
	task automatic t_badkey();
		logic [7:0] bad[2];
		bad = '{KEY_SECOND, 8'h5A};
		foreach (bad[i]) begin
			do_reset();
			setup();
			u_core.reg_write(KEY_OFS, bad[i]);
			chk_reg("status", STATUS_OFS, 8'h1E);
			prog(16'h0230, 8'h00, n);
			chk("blocked stall", 0, n);
			chk_code(14'h0230, ERASED_BYTE);
		end
		$display("test badkey done");
	endtask : t_badkey

	// attempt before keys blocks
	task automatic t_nokey();
		do_reset();
		setup();
		u_core.reg_write(CTRL_OFS, 8'h01);
		u_core.external_move_instruction(16'h0230, 8'h00);
		op_len(n);
		chk("nokey stall", 0, n);
		u_core.unlock();
		chk_reg("status", STATUS_OFS, 8'h1E);
		$display("test nokey done");
	endtask : t_nokey

	// uninitialised store ignores software writes
	task automatic t_uninit();
		do_reset();
		setup();
		store_initialised <= 1'b0;
		repeat (3) @(posedge clk_sys);
		prog(16'h0230, 8'h00, n);
		chk("uninit stall", 0, n);
		chk_code(14'h0230, ERASED_BYTE);
		chk_reg("status", STATUS_OFS, 8'h04);
		store_initialised <= 1'b1;
		$display("test uninit done");
	endtask : t_uninit

	// counts and verdict
	task automatic end_of_test();
		$display("compared %0d miscompared %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : end_of_test

	// main sequence
	initial begin
		do_reset();
		t_plain();
		t_error();
		t_erase();
		t_single();
		t_block();
		t_badkey();
		t_nokey();
		t_uninit();
		end_of_test();
	end
endmodule : tb_top
